// file: core/dsp_irq_ctrl.sv
`timescale 1ns/1ps
`include "irq_ctrl_map.svh"
module dsp_irq_ctrl (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic [15:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rdata_o,
  // external interrupt pins, active low
  input wire logic [47:0] pin_n_i,
  // boot hold, from a pin
  input wire logic boot_i,
  // peripheral side
  input wire logic [47:0] periph_ready_i,
  input wire logic [47:0] dummy_access_i,
  input wire logic reboot_host_i,
  input wire logic reboot_serial_i,
  // core side
  input wire logic [11:0] core_status_mask_i,
  input wire logic [11:0] core_ack_i,
  input wire logic discard_i,
  output logic [11:0] core_req_o,
  output logic [11:0] core_irq_n_o,
  output logic [47:0] access_enable_o
);
  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic [47:0] pin_meta_r;
  logic [47:0] pin_sync_r;
  logic boot_meta_r;
  logic boot_sync_r;
  logic [47:0] acc_r;
  logic [47:0] acc_set;
  logic [47:0] fac_n;
  logic [11:0] port_hit;
  logic [11:0] irq_n_w;
  logic [11:0] irq_prev_r;
  logic [11:0] core_fall;
  logic [11:0] pend_r;
  logic [8:0] ctrl_w [`IRQ_NPORT];
  logic [15:0] rdata_r;
  logic [3:0] port_idx;
  logic addr_ok;

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  // pins and boot strap are asynchronous to ref_clk_i
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_meta_r <= 48'hFFFF_FFFF_FFFF;
      pin_sync_r <= 48'hFFFF_FFFF_FFFF;
    end else begin
      pin_meta_r <= pin_n_i;
      pin_sync_r <= pin_meta_r;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      boot_meta_r <= 1'b0;
      boot_sync_r <= 1'b0;
    end else begin
      boot_meta_r <= boot_i;
      boot_sync_r <= boot_meta_r;
    end
  end

  // ---------------------------------------------------------------
  // peripheral access-enable flags
  // ---------------------------------------------------------------
  // a reboot leaves the host or serial input flag set, so that
  // line stays low and, in mask mode, fires once its factor is unmasked
  always_comb begin
    acc_set = periph_ready_i;
    acc_set[`HOST_IN_LINE] = periph_ready_i[`HOST_IN_LINE] | reboot_host_i;
    acc_set[`SERIAL_IN_LINE] = periph_ready_i[`SERIAL_IN_LINE] | reboot_serial_i;
  end

  // set wins over a dummy access in the same cycle; discard_i is
  // deliberately not a term here
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      acc_r <= 48'h0;
    end else begin
      acc_r <= (acc_r & ~dummy_access_i) | acc_set;
    end
  end

  assign access_enable_o = acc_r;

  // line is low while either the pin or the flag holds it there
  assign fac_n = pin_sync_r & ~acc_r;

  // ---------------------------------------------------------------
  // register decode
  // ---------------------------------------------------------------
  assign port_idx = 4'(addr_i - `FCR_BASE);
  assign addr_ok = (addr_i >= `FCR_BASE) && (addr_i < `FCR_BASE + 8'(`IRQ_NPORT));

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_r <= 16'h0000;
    end else if (rd_i && addr_ok) begin
      rdata_r <= {7'h00, ctrl_w[port_idx]};
    end else begin
      rdata_r <= 16'h0000;
    end
  end

  assign rdata_o = rdata_r;

  // ---------------------------------------------------------------
  // per port factor controllers and core latches
  // ---------------------------------------------------------------
  genvar p;
  generate
    for (p = 0; p < `IRQ_NPORT; p++) begin : g_port
      assign port_hit[p] = wr_i && addr_ok && (port_idx == 4'(p));

      factor_port_ctrl u_ctrl (
        .ref_clk_i(ref_clk_i),
        .rst_n_i(rst_n_i),
        .load_i(port_hit[p]),
        .wdata_i(wdata_i),
        .boot_i(boot_sync_r),
        .fac_n_i(fac_n[4*p +: 4]),
        .ctrl_o(ctrl_w[p]),
        .irq_n_o(irq_n_w[p])
      );

      // the core only reacts to a falling edge of its port
      assign core_fall[p] = irq_prev_r[p] & ~irq_n_w[p];

      // a new edge wins over an ack or discard in the same cycle
      always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          pend_r[p] <= 1'b0;
        end else if (core_fall[p]) begin
          pend_r[p] <= 1'b1;
        end else if (discard_i || core_ack_i[p]) begin
          pend_r[p] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_prev_r <= 12'hFFF;
    end else begin
      irq_prev_r <= irq_n_w;
    end
  end

  assign core_irq_n_o = irq_n_w;

  // pending survives the status mask and is served once lifted
  assign core_req_o = pend_r & ~core_status_mask_i;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  chk_pend_kept_masked: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (|(pend_r & core_status_mask_i) && !discard_i && core_ack_i == 12'h000)
      |=> (pend_r & $past(pend_r)) == $past(pend_r))
    else $error("masked pending request lost");
  chk_discard_clears: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (discard_i && core_fall == 12'h000) |=> pend_r == 12'h000)
    else $error("discard left a pending request");
  chk_discard_keeps_acc: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (discard_i && dummy_access_i == 48'h0) |=> (acc_r & $past(acc_r)) == $past(acc_r))
    else $error("discard touched access flags");
  chk_acc_withholds: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    acc_r[0] && !dummy_access_i[0] |=> acc_r[0] && !fac_n[0])
    else $error("access flag dropped without access");
  chk_dummy_clears: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    dummy_access_i[0] && !acc_set[0] |=> !acc_r[0])
    else $error("dummy access did not clear flag");
  chk_edge_to_pend: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    core_fall[0] |=> pend_r[0] ##0 core_req_o[0] == !core_status_mask_i[0])
    else $error("falling edge not latched");
  chk_reboot_pending: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    reboot_host_i |=> acc_r[`HOST_IN_LINE] && !fac_n[`HOST_IN_LINE])
    else $error("reboot left no pending host input");
  chk_masked_no_pend: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (ctrl_w[0][`FCR_MASK_MSB:`FCR_MASK_LSB] == 4'h0 && irq_n_w[0]) |=> !core_fall[0])
    else $error("masked factor reached core");

  chk_reboot_serial: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    reboot_serial_i |=> acc_r[`SERIAL_IN_LINE] && !fac_n[`SERIAL_IN_LINE])
    else $error("reboot left no pending serial input");

  chk_rdata_idle: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    !rd_i |=> rdata_o == 16'h0000)
    else $error("read data stood without a read");

  chk_rdata_unmapped: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (rd_i && !addr_ok) |=> rdata_o == 16'h0000)
    else $error("unmapped read returned data");

  chk_rdata_upper: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    rd_i |=> rdata_o[15:9] == 7'h00)
    else $error("unused read bits not zero");

  // ---------------------------------------------------------------
  // per port checks
  // ---------------------------------------------------------------
  // several checks above sample port 0 only; these watch all twelve
  genvar pc;
  generate
    for (pc = 0; pc < `IRQ_NPORT; pc++) begin : g_port_chk
      chk_port_wr_mode: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        port_hit[pc] |=> ctrl_w[pc][`FCR_MODE_BIT] == $past(wdata_i[`FCR_MODE_BIT]))
        else $error("mode bit not loaded");

      chk_port_wr_mask: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        port_hit[pc] |=> ctrl_w[pc][`FCR_MASK_MSB:`FCR_MASK_LSB]
          == $past(wdata_i[`FCR_MASK_MSB:`FCR_MASK_LSB]))
        else $error("mask bits not loaded");

      chk_port_keeps_ctrl: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        !port_hit[pc] |=> ctrl_w[pc][`FCR_MODE_BIT:`FCR_MASK_LSB]
          == $past(ctrl_w[pc][`FCR_MODE_BIT:`FCR_MASK_LSB]))
        else $error("control changed without a write");

      chk_port_read: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (rd_i && addr_ok && port_idx == 4'(pc)) |=> rdata_o == {7'h00, $past(ctrl_w[pc])})
        else $error("read data not the port control");

      chk_port_fall_pend: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        core_fall[pc] |=> pend_r[pc])
        else $error("port edge not latched");

      chk_port_ack_clears: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (core_ack_i[pc] && !core_fall[pc]) |=> !pend_r[pc])
        else $error("ack left request pending");

      chk_port_discard: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (discard_i && !core_fall[pc]) |=> !pend_r[pc])
        else $error("discard left port pending");

      chk_port_pend_holds: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (pend_r[pc] && !core_ack_i[pc] && !discard_i) |=> pend_r[pc])
        else $error("pending request dropped");

      chk_port_no_spurious: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (!pend_r[pc] && !core_fall[pc]) |=> !pend_r[pc])
        else $error("request latched without edge");

      chk_port_smask_blocks: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        core_status_mask_i[pc] |-> !core_req_o[pc])
        else $error("status mask did not hold request");

      chk_port_req_open: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (pend_r[pc] && !core_status_mask_i[pc]) |-> core_req_o[pc])
        else $error("unmasked pending not served");

      chk_port_boot_high: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        boot_sync_r |=> irq_n_w[pc])
        else $error("port active during boot");

      chk_port_masked_high: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        ctrl_w[pc][`FCR_MASK_MSB:`FCR_MASK_LSB] == 4'h0 |=> irq_n_w[pc])
        else $error("fully masked port went low");

      chk_port_blank_load: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        port_hit[pc] |=> irq_n_w[pc] [*4])
        else $error("port not blanked after load");

      chk_port_no_refire: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        !irq_n_w[pc] |=> !core_fall[pc])
        else $error("edge seen on a held low port");
    end
  endgenerate

  // ---------------------------------------------------------------
  // per line checks
  // ---------------------------------------------------------------
  // a line is a pin and an access flag; either one pulls it low
  genvar lc;
  generate
    for (lc = 0; lc < `IRQ_NLINE; lc++) begin : g_line_chk
      chk_line_sets: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        acc_set[lc] |=> acc_r[lc] && !fac_n[lc])
        else $error("ready did not raise line");

      chk_line_withholds: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (acc_r[lc] && !dummy_access_i[lc]) |=> acc_r[lc])
        else $error("line flag dropped without access");

      chk_line_clears: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (dummy_access_i[lc] && !acc_set[lc]) |=> !acc_r[lc])
        else $error("dummy access left line flag");

      chk_line_set_wins: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (acc_set[lc] && dummy_access_i[lc]) |=> acc_r[lc])
        else $error("access beat a new request");

      chk_line_discard: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (discard_i && acc_r[lc] && !dummy_access_i[lc]) |=> acc_r[lc])
        else $error("discard cleared a line flag");

      chk_line_pin_low: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        !pin_sync_r[lc] |-> !fac_n[lc])
        else $error("low pin not on its line");

      chk_line_idle_high: assert property (
        @(posedge ref_clk_i) disable iff (!rst_n_i)
        (pin_sync_r[lc] && !acc_r[lc]) |-> fac_n[lc])
        else $error("idle line not high");
    end
  endgenerate
endmodule : dsp_irq_ctrl

// file: core/irq_ctrl_map.svh
`ifndef IRQ_CTRL_MAP_SVH
`define IRQ_CTRL_MAP_SVH

// geometry
`define IRQ_NPORT 12
`define IRQ_NFACT 4
`define IRQ_NLINE 48
// factor control register, one per core port at base plus port index
`define FCR_BASE 8'h00
`define FCR_MODE_BIT 8
`define FCR_MASK_MSB 7
`define FCR_MASK_LSB 4
`define FCR_STAMP_MSB 3
`define FCR_STAMP_LSB 0
`define FCR_MODE_RST 1'b0
`define FCR_MASK_RST 4'h0
`define FCR_STAMP_RST 4'h0
// output blanking after a control load, in cycles
`define BLANK_CYC 3'h4
// lines whose access-enable flag a reboot leaves set
`define HOST_IN_LINE 32
`define SERIAL_IN_LINE 24
`endif

// file: core/irq_ctrl_pkg.sv
package irq_ctrl_pkg;
  typedef enum logic [1:0] {
    BLK_RUN = 2'b01,
    BLK_HOLD = 2'b10
  } blank_st_t;
  typedef enum logic {
    MODE_MASK = 1'b0,
    MODE_STAMP = 1'b1
  } mode_t;
  typedef logic [3:0] factor_t;
endpackage : irq_ctrl_pkg

// file: core/factor_port_ctrl.sv
`timescale 1ns/1ps
`include "irq_ctrl_map.svh"
module factor_port_ctrl (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // register load
  input wire logic load_i,
  input wire logic [15:0] wdata_i,
  // boot hold
  input wire logic boot_i,
  // factor lines, active low
  input wire logic [3:0] fac_n_i,
  // status and core output
  output logic [8:0] ctrl_o,
  output logic irq_n_o
);
  irq_ctrl_pkg::mode_t mode_r;
  irq_ctrl_pkg::factor_t mask_r;
  irq_ctrl_pkg::factor_t stamp_r;
  irq_ctrl_pkg::factor_t prev_n_r;
  irq_ctrl_pkg::factor_t eff_mask;
  irq_ctrl_pkg::factor_t fall;
  irq_ctrl_pkg::blank_st_t blk_r;
  logic [2:0] cnt_r;
  logic force_hi;
  logic irq_n_r;

  assign eff_mask = boot_i ? 4'h0 : mask_r;
  assign fall = prev_n_r & ~fac_n_i;
  assign force_hi = load_i | (blk_r == irq_ctrl_pkg::BLK_HOLD);
  assign ctrl_o = {mode_r, mask_r, stamp_r};
  assign irq_n_o = irq_n_r;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_r <= irq_ctrl_pkg::MODE_MASK;
      mask_r <= `FCR_MASK_RST;
    end else if (load_i) begin
      mode_r <= irq_ctrl_pkg::mode_t'(wdata_i[`FCR_MODE_BIT]);
      mask_r <= wdata_i[`FCR_MASK_MSB:`FCR_MASK_LSB];
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prev_n_r <= 4'hF;
    end else begin
      prev_n_r <= fac_n_i;
    end
  end

  // a stamp arriving with the load survives it
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stamp_r <= `FCR_STAMP_RST;
    end else if (mode_r == irq_ctrl_pkg::MODE_STAMP) begin
      stamp_r <= (load_i ? 4'h0 : stamp_r) | (fall & eff_mask);
    end else begin
      stamp_r <= load_i ? 4'h0 : stamp_r;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      blk_r <= irq_ctrl_pkg::BLK_RUN;
      cnt_r <= 3'h0;
    end else if (load_i) begin
      blk_r <= irq_ctrl_pkg::BLK_HOLD;
      // the load edge already blanks one cycle, the hold covers the rest
      cnt_r <= `BLANK_CYC - 3'h2;
    end else begin
      unique case (blk_r)
        irq_ctrl_pkg::BLK_RUN: begin
          cnt_r <= 3'h0;
        end
        irq_ctrl_pkg::BLK_HOLD: begin
          if (cnt_r == 3'h0) begin
            blk_r <= irq_ctrl_pkg::BLK_RUN;
          end
          cnt_r <= cnt_r - 3'h1;
        end
        default: begin
          blk_r <= irq_ctrl_pkg::BLK_RUN;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_n_r <= 1'b1;
    end else if (force_hi) begin
      irq_n_r <= 1'b1;
    end else if (mode_r == irq_ctrl_pkg::MODE_STAMP) begin
      // gated so a boot hold also silences stamps taken before it
      irq_n_r <= ~|(stamp_r & eff_mask);
    end else begin
      irq_n_r <= ~|(~fac_n_i & eff_mask);
    end
  end

  chk_load_blanks_out: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i) load_i |=> irq_n_r [*4])
    else $error("output not blanked after load");
  chk_boot_holds_high: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i) boot_i |=> irq_n_r)
    else $error("interrupt passed during boot");
  chk_mask_level_pass: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (mode_r == irq_ctrl_pkg::MODE_MASK && !force_hi)
      |=> irq_n_r == ~|($past(~fac_n_i) & $past(eff_mask)))
    else $error("mask mode level not passed");
  chk_stamp_edge_set: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (mode_r == irq_ctrl_pkg::MODE_STAMP && |(fall & eff_mask))
      |=> |stamp_r ##1 (!force_hi && !boot_i) |=> !irq_n_r)
    else $error("stamp edge lost");
  chk_stamp_or_out: assert property (
    @(posedge ref_clk_i) disable iff (!rst_n_i)
    (mode_r == irq_ctrl_pkg::MODE_STAMP && !force_hi && stamp_r == 4'h0) |=> irq_n_r)
    else $error("stamp output low without stamp");
endmodule : factor_port_ctrl

// file: tb/core_ack_model.sv
`timescale 1ns/1ps
// ----
// core side: vector fetch acknowledges each raised request unless stall_i holds it off
// ----
module core_ack_model #(
  parameter int DELAY = 3
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // core view
  input wire logic [11:0] req_i,
  input wire logic stall_i,
  output logic [11:0] ack_o
);
  logic [3:0] cnt_r [12];

  // stall mimics a core busy elsewhere, so a request can be held and seen
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ack_o <= 12'h000;
      for (int i = 0; i < 12; i++) begin
        cnt_r[i] <= 4'h0;
      end
    end else begin
      for (int i = 0; i < 12; i++) begin
        ack_o[i] <= 1'b0;
        if (ack_o[i] || !req_i[i] || stall_i) begin
          cnt_r[i] <= 4'h0;
        end else if (cnt_r[i] == 4'(DELAY - 1)) begin
          ack_o[i] <= 1'b1;
        end else begin
          cnt_r[i] <= cnt_r[i] + 4'h1;
        end
      end
    end
  end
endmodule : core_ack_model

// file: tb/tb_dsp_interrupt_mask_stamp_control.sv
`timescale 1ns/1ps
module tb_dsp_interrupt_mask_stamp_control;
  typedef struct packed {
    logic [3:0] port;
    logic mode;
    logic [3:0] mask;
    logic [1:0] fac;
    logic irq_n;
  } row_t;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic [47:0] pin_n = 48'hFFFFFFFFFFFF;
  logic boot = 1'b0;
  logic [47:0] ready = 48'h0;
  logic [47:0] dacc = 48'h0;
  logic rb_h = 1'b0;
  logic rb_s = 1'b0;
  logic [11:0] smask = 12'h000;
  logic discard = 1'b0;
  logic stall = 1'b0;
  logic [15:0] rdata;
  logic [11:0] req;
  logic [11:0] irq_n;
  logic [11:0] ack;
  logic [47:0] acc;
  int n_mismatch = 0;
  int num_checks = 0;
  row_t rows [6] = '{
    '{4'h0, 1'b0, 4'h1, 2'h0, 1'b0},
    '{4'h3, 1'b0, 4'hE, 2'h0, 1'b1},
    '{4'h7, 1'b0, 4'h8, 2'h3, 1'b0},
    '{4'hB, 1'b1, 4'h4, 2'h2, 1'b0},
    '{4'h4, 1'b1, 4'hB, 2'h2, 1'b1},
    '{4'h9, 1'b1, 4'h2, 2'h1, 1'b0}
  };

  dsp_irq_ctrl dut (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .addr_i(addr),
    .wdata_i(wdata),
    .wr_i(wr_s),
    .rd_i(rd_s),
    .rdata_o(rdata),
    .pin_n_i(pin_n),
    .boot_i(boot),
    .periph_ready_i(ready),
    .dummy_access_i(dacc),
    .reboot_host_i(rb_h),
    .reboot_serial_i(rb_s),
    .core_status_mask_i(smask),
    .core_ack_i(ack),
    .discard_i(discard),
    .core_req_o(req),
    .core_irq_n_o(irq_n),
    .access_enable_o(acc)
  );
  core_ack_model core_model (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .req_i(req),
    .stall_i(stall),
    .ack_o(ack)
  );

  initial begin
    forever #50 ref_clk_i = ~ref_clk_i;
  end

  // ----
  // helpers
  // ----
  task automatic w(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask : w
  task automatic ck(input logic [47:0] g, input logic [47:0] e, input string s);
    num_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, s, g, e);
    end
  endtask : ck
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    w(1);
    wr_s <= 1'b0;
  endtask : wr
  // data stand one cycle only, so sample in that cycle
  task automatic rd(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
    addr <= a;
    rd_s <= 1'b1;
    w(1);
    rd_s <= 1'b0;
    @(negedge ref_clk_i);
    ck(48'(rdata & m), 48'(e & m), "rdata");
    w(1);
  endtask : rd
  task automatic wait_req(input int p);
    int i;
    i = 0;
    while (req[p] !== 1'b1 && i < 20) begin
      @(negedge ref_clk_i);
      i++;
    end
    ck(48'(req[p]), 48'h1, "req wait");
    if (i == 20) begin
      finish_test();
    end
    w(1);
  endtask : wait_req
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : finish_test

  // ----
  // sequence
  // ----
  initial begin
    row_t r;
    int k;
    logic [3:0] st;
    w(5);
    rst_n_i <= 1'b1;
    w(2);
    @(negedge ref_clk_i);
    ck(48'({irq_n, req}), 48'hFFF000, "idle core");
    ck(acc, 48'h0, "idle acc");
    w(1);
    rd(8'h00, 16'h01FF, 16'h0000);
    wr(8'h0C, 16'h01F0);
    rd(8'h0C, 16'hFFFF, 16'h0000);
    $display("reset test done");
    foreach (rows[i]) begin
      r = rows[i];
      k = 4 * int'(r.port) + int'(r.fac);
      st = {4{r.mode}} & r.mask & (4'h1 << r.fac);
      wr(8'(r.port), {7'h00, r.mode, r.mask, 4'h0});
      w(8);
      pin_n[k] <= 1'b0;
      w(6);
      @(negedge ref_clk_i);
      ck(48'(irq_n[r.port]), 48'(r.irq_n), "fall");
      w(1);
      rd(8'(r.port), {7'h00, 5'h1F, {4{r.mode}}}, {7'h00, r.mode, r.mask, st});
      pin_n[k] <= 1'b1;
      w(6);
      @(negedge ref_clk_i);
      ck(48'(irq_n[r.port]), 48'(r.mode ? r.irq_n : 1'b1), "rise");
      w(1);
      wr(8'(r.port), 16'h0000);
      w(6);
    end
    $display("row test done");
    for (int m = 0; m < 2; m++) begin
      pin_n[4] <= 1'b0;
      w(4);
      wr(8'h01, {7'h00, 1'(m), 4'h1, 4'h0});
      w(8);
      @(negedge ref_clk_i);
      ck(48'(irq_n[1]), 48'(m), "held low");
      w(1);
      rd(8'h01, {12'h000, {4{1'(m)}}}, 16'h0000);
      pin_n[4] <= 1'b1;
      wr(8'h01, 16'h0000);
      w(6);
    end
    pin_n[9] <= 1'b0;
    wr(8'h02, 16'h0020);
    w(8);
    wr(8'h02, 16'h0020);
    repeat (4) begin
      @(negedge ref_clk_i);
      ck(48'(irq_n[2]), 48'h1, "blank");
    end
    @(negedge ref_clk_i);
    ck(48'(irq_n[2]), 48'h0, "unblank");
    w(1);
    pin_n[9] <= 1'b1;
    wr(8'h02, 16'h0120);
    w(8);
    wr(8'h02, 16'h0120);
    // fall lands inside the blanking window: the new stamp must survive
    pin_n[9] <= 1'b0;
    w(8);
    @(negedge ref_clk_i);
    ck(48'(irq_n[2]), 48'h0, "stamp wins");
    w(1);
    rd(8'h02, 16'h01FF, 16'h0122);
    pin_n[9] <= 1'b1;
    wr(8'h02, 16'h0000);
    $display("held and blank tests done");
    w(1);
    smask[0] <= 1'b1;
    wr(8'h00, 16'h0010);
    w(6);
    pin_n[0] <= 1'b0;
    w(6);
    @(negedge ref_clk_i);
    ck(48'(req[0]), 48'h0, "core masked");
    w(1);
    smask[0] <= 1'b0;
    @(negedge ref_clk_i);
    ck(48'(req[0]), 48'h1, "kept req");
    w(8);
    @(negedge ref_clk_i);
    ck(48'(req[0]), 48'h0, "level only");
    w(1);
    pin_n[0] <= 1'b1;
    smask[0] <= 1'b1;
    w(4);
    pin_n[0] <= 1'b0;
    w(6);
    discard <= 1'b1;
    w(1);
    discard <= 1'b0;
    smask[0] <= 1'b0;
    @(negedge ref_clk_i);
    ck(48'(req[0]), 48'h0, "discarded");
    w(1);
    pin_n[0] <= 1'b1;
    wr(8'h00, 16'h0000);
    $display("core latch test done");
    w(1);
    wr(8'h05, 16'h0010);
    dacc[20] <= 1'b1;
    w(1);
    dacc[20] <= 1'b0;
    w(6);
    stall <= 1'b1;
    ready[20] <= 1'b1;
    w(1);
    ready[20] <= 1'b0;
    @(negedge ref_clk_i);
    ck(acc, 48'h1 << 20, "acc set");
    w(3);
    @(negedge ref_clk_i);
    ck(48'({irq_n[5], req[5]}), 48'h1, "periph irq");
    w(1);
    smask[5] <= 1'b1;
    discard <= 1'b1;
    w(1);
    discard <= 1'b0;
    ready[20] <= 1'b1;
    w(1);
    ready[20] <= 1'b0;
    smask[5] <= 1'b0;
    w(4);
    @(negedge ref_clk_i);
    ck(48'({acc[20], req[5]}), 48'h2, "flag kept");
    w(1);
    dacc[20] <= 1'b1;
    w(1);
    dacc[20] <= 1'b0;
    w(2);
    @(negedge ref_clk_i);
    ck(48'({acc[20], irq_n[5]}), 48'h1, "dummy access");
    w(1);
    ready[20] <= 1'b1;
    w(1);
    ready[20] <= 1'b0;
    wait_req(5);
    $display("peripheral test done");
    smask[8] <= 1'b1;
    boot <= 1'b1;
    w(3);
    wr(8'h08, 16'h0010);
    rb_h <= 1'b1;
    rb_s <= 1'b1;
    w(1);
    rb_h <= 1'b0;
    rb_s <= 1'b0;
    w(5);
    @(negedge ref_clk_i);
    ck(acc & 48'h101000000, 48'h101000000, "reboot");
    ck(48'(irq_n[8]), 48'h1, "boot masked");
    w(1);
    wr(8'h08, 16'h0000);
    boot <= 1'b0;
    w(4);
    smask[8] <= 1'b0;
    wr(8'h08, 16'h0010);
    wait_req(8);
    stall <= 1'b0;
    $display("reboot test done");
    w(10);
    rst_n_i <= 1'b0;
    w(2);
    @(negedge ref_clk_i);
    ck(48'({irq_n, req}), 48'hFFF000, "reset core");
    ck(acc, 48'h0, "reset acc");
    w(1);
    rst_n_i <= 1'b1;
    w(2);
    rd(8'h08, 16'h01FF, 16'h0000);
    $display("mid-run reset test done");
    finish_test();
  end
endmodule : tb_dsp_interrupt_mask_stamp_control
